// File: rtl/wsa_pkg.sv
`default_nettype none
package wsa_pkg;
  // clock and timing
  localparam longint CLK_PERIOD_PS = 64'd25000;
  localparam longint SEC_PS        = 64'd1000000000000;
  localparam int     TICK_CYC      = int'(SEC_PS / CLK_PERIOD_PS);
  localparam int     FAST_PERIOD_S = 10;
  localparam int     SLOW_PERIOD_S = 60;

  // data widths
  localparam int DW   = 16;
  localparam int SUMW = 32;
  localparam int CNTW = 16;
  localparam int LVLW = 4;
  localparam int DSTW = 8;

  // spike rejection
  localparam int RUN_DEPTH    = 10;
  localparam int RUN_PTRW     = 4;
  localparam int SPIKE_FACTOR = 8;

  // lightning threshold
  localparam logic [LVLW-1:0] THR_DEFAULT = 4'h5;

  // rain, depth in micrometres per drop
  localparam logic [15:0] DROP_BASE_UM   = 16'h0011;
  localparam logic [15:0] DROP_CUT_MAX   = 16'h0008;
  localparam int          DROP_CUT_SHIFT = 4;
  localparam logic [31:0] UM_TO_MMH_MUL  = 32'h0000_0003;
  localparam logic [31:0] UM_TO_MMH_DIV  = 32'h0000_0032;
  localparam logic [15:0] INT_CAP_MMH    = 16'h0118;
endpackage
`default_nettype wire

// File: rtl/wsa_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wsa_tick #(
  parameter int TICK_CYCLES = wsa_pkg::TICK_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      fast_smp,
  output logic      slow_smp
);
  logic [31:0] cyc_q, cyc_d;
  logic [7:0]  fs_q,  fs_d;
  logic [7:0]  ss_q,  ss_d;
  logic        sec;

  always_comb begin
    sec      = (cyc_q == 32'(TICK_CYCLES - 1));
    cyc_d    = sec ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
    fs_d     = fs_q;
    ss_d     = ss_q;
    fast_smp = 1'b0;
    slow_smp = 1'b0;
    if (sec) begin
      fast_smp = (fs_q == 8'(wsa_pkg::FAST_PERIOD_S - 1));
      slow_smp = (ss_q == 8'(wsa_pkg::SLOW_PERIOD_S - 1));
      fs_d     = fast_smp ? 8'h00 : fs_q + 8'h01;
      ss_d     = slow_smp ? 8'h00 : ss_q + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= 32'h0000_0000;
      fs_q  <= 8'h00;
      ss_q  <= 8'h00;
    end else begin
      cyc_q <= cyc_d;
      fs_q  <= fs_d;
      ss_q  <= ss_d;
    end
  end
endmodule // wsa_tick
`default_nettype wire

// File: rtl/wsa_acc.sv
`timescale 1ns/1ps
`default_nettype none
module wsa_acc (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              add,
  input  wire logic signed [wsa_pkg::DW-1:0]     val,
  input  wire logic                              clr,
  output logic signed      [wsa_pkg::SUMW-1:0]   sum_q,
  output logic             [wsa_pkg::CNTW-1:0]   cnt_q
);
  logic signed [wsa_pkg::SUMW-1:0] sum_d;
  logic        [wsa_pkg::CNTW-1:0] cnt_d;

  // a sample in the clearing cycle opens the new interval
  always_comb begin
    sum_d = clr ? '0 : sum_q;
    cnt_d = clr ? '0 : cnt_q;
    if (add) begin
      sum_d = sum_d + wsa_pkg::SUMW'(val);
      cnt_d = (cnt_d == '1) ? cnt_d : cnt_d + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_q <= '0;
      cnt_q <= '0;
    end else begin
      sum_q <= sum_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // wsa_acc
`default_nettype wire

// File: rtl/wsa_top.sv
// Notes on behaviour
// - one wind vector sample every 10 s while powered, kept for averaging.
// - query reports mean accepted wind speed, direction vector and largest accepted speed.
// - running mean over the last ten wind speed samples, updated each wind sample.
// - speed above eight times the running mean is a spike and is rejected.
// - rejected spike joins neither gust nor wind averages.
// - no accepted wind data in an interval reports an error instead.
// - vapour pressure sampled every 60 s, mean reported per query.
// - every rain drop added to a total, query returns rainfall since last query.
// - maximum precipitation intensity saturates at 280 mm/h.
// - per-drop depth shrinks as rain intensity rises.
// - air temperature sampled every 10 s, mean reported per query.
// - every lightning event with level above the threshold counted, query returns count since last query.
// - mean distance of counted strikes reported with the count.
// - lightning threshold holds 0 to 15, defaults to 5.
// - higher threshold rejects more disturbances as noise.
// - barometric pressure sampled every 60 s, mean reported per query.
`timescale 1ns/1ps
`default_nettype none
module wsa_top #(
  parameter int TICK_CYCLES = wsa_pkg::TICK_CYC
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  wire logic                                 query,
  input  wire logic signed [wsa_pkg::DW-1:0]        wind_u,
  input  wire logic signed [wsa_pkg::DW-1:0]        wind_v,
  input  wire logic signed [wsa_pkg::DW-1:0]        wind_speed,
  input  wire logic signed [wsa_pkg::DW-1:0]        air_temp,
  input  wire logic signed [wsa_pkg::DW-1:0]        vapour,
  input  wire logic signed [wsa_pkg::DW-1:0]        baro,
  input  wire logic                                 rain_drop,
  input  wire logic                                 strike_evt,
  input  wire logic        [wsa_pkg::LVLW-1:0]      strike_level,
  input  wire logic        [wsa_pkg::DSTW-1:0]      strike_dist,
  input  wire logic        [wsa_pkg::LVLW-1:0]      thr_value,
  input  wire logic                                 thr_save,
  output logic                                      fast_sample,
  output logic                                      slow_sample,
  output logic                                      spike_q,
  output logic                                      report_valid_q,
  output logic                                      wind_error_q,
  output logic signed      [wsa_pkg::DW-1:0]        wind_u_mean_q,
  output logic signed      [wsa_pkg::DW-1:0]        wind_v_mean_q,
  output logic signed      [wsa_pkg::DW-1:0]        wind_speed_mean_q,
  output logic signed      [wsa_pkg::DW-1:0]        wind_gust_q,
  output logic signed      [wsa_pkg::DW-1:0]        temp_mean_q,
  output logic signed      [wsa_pkg::DW-1:0]        vapour_mean_q,
  output logic signed      [wsa_pkg::DW-1:0]        baro_mean_q,
  output logic             [31:0]                   rain_total_q,
  output logic             [15:0]                   rain_max_mmh_q,
  output logic             [wsa_pkg::CNTW-1:0]      strike_count_q,
  output logic             [wsa_pkg::DSTW-1:0]      strike_dist_mean_q,
  output logic             [wsa_pkg::LVLW-1:0]      thr_level_q
);
  typedef logic signed [wsa_pkg::SUMW-1:0] wsa_sum_t;
  typedef logic        [wsa_pkg::CNTW-1:0] wsa_cnt_t;

  function automatic logic signed [wsa_pkg::DW-1:0] mean_of(input wsa_sum_t s, input wsa_cnt_t n);
    wsa_sum_t q;
    q = '0;
    if (n != '0) begin
      q = s / $signed({{(wsa_pkg::SUMW-wsa_pkg::CNTW){1'b0}}, n});
    end
    return q[wsa_pkg::DW-1:0];
  endfunction

  // sample schedule
  wsa_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk      (clk),
    .rst      (rst),
    .fast_smp (fast_sample),
    .slow_smp (slow_sample)
  );

  // running mean and spike test
  logic [wsa_pkg::DW-1:0]       ring_q [wsa_pkg::RUN_DEPTH];
  logic [wsa_pkg::DW-1:0]       ring_d [wsa_pkg::RUN_DEPTH];
  logic [wsa_pkg::RUN_PTRW-1:0] ptr_q, ptr_d, fill_q, fill_d;
  logic [31:0]                  rsum_q, rsum_d;
  logic [wsa_pkg::DW-1:0]       spd_u;
  logic [39:0]                  lhs, rhs;
  logic                         spike, wind_ok, spike_d;

  always_comb begin
    spd_u   = wind_speed[wsa_pkg::DW-1] ? '0 : wind_speed;
    // speed > 8 * (sum / fill) without a divider
    lhs     = 40'(spd_u) * 40'(fill_q);
    rhs     = 40'(rsum_q) * 40'(wsa_pkg::SPIKE_FACTOR);
    spike   = fast_sample && (fill_q != '0) && (lhs > rhs);
    wind_ok = fast_sample && !spike;
    spike_d = spike;
    ring_d  = ring_q;
    ptr_d   = ptr_q;
    fill_d  = fill_q;
    rsum_d  = rsum_q;
    if (fast_sample) begin
      // every sample enters the window so a real step is accepted later
      rsum_d       = rsum_q - 32'(ring_q[ptr_q]) + 32'(spd_u);
      ring_d[ptr_q] = spd_u;
      ptr_d        = (ptr_q == wsa_pkg::RUN_PTRW'(wsa_pkg::RUN_DEPTH - 1)) ? '0 : ptr_q + 1'b1;
      fill_d       = (fill_q == wsa_pkg::RUN_PTRW'(wsa_pkg::RUN_DEPTH)) ? fill_q : fill_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < wsa_pkg::RUN_DEPTH; i++) begin
        ring_q[i] <= '0;
      end
      ptr_q   <= '0;
      fill_q  <= '0;
      rsum_q  <= 32'h0000_0000;
      spike_q <= 1'b0;
    end else begin
      ring_q  <= ring_d;
      ptr_q   <= ptr_d;
      fill_q  <= fill_d;
      rsum_q  <= rsum_d;
      spike_q <= spike_d;
    end
  end

  // interval accumulators
  wsa_sum_t u_sum, v_sum, s_sum, t_sum, e_sum, p_sum, d_sum;
  wsa_cnt_t u_cnt, v_cnt, s_cnt, t_cnt, e_cnt, p_cnt, d_cnt;
  logic     strike_ok;

  always_comb begin
    strike_ok = strike_evt && (strike_level > thr_level_q);
  end

  wsa_acc u_acc_u (
    .clk   (clk),
    .rst   (rst),
    .add   (wind_ok),
    .val   (wind_u),
    .clr   (query),
    .sum_q (u_sum),
    .cnt_q (u_cnt)
  );
  wsa_acc u_acc_v (
    .clk   (clk),
    .rst   (rst),
    .add   (wind_ok),
    .val   (wind_v),
    .clr   (query),
    .sum_q (v_sum),
    .cnt_q (v_cnt)
  );
  wsa_acc u_acc_s (
    .clk   (clk),
    .rst   (rst),
    .add   (wind_ok),
    .val   (wind_speed),
    .clr   (query),
    .sum_q (s_sum),
    .cnt_q (s_cnt)
  );
  wsa_acc u_acc_t (
    .clk   (clk),
    .rst   (rst),
    .add   (fast_sample),
    .val   (air_temp),
    .clr   (query),
    .sum_q (t_sum),
    .cnt_q (t_cnt)
  );
  wsa_acc u_acc_e (
    .clk   (clk),
    .rst   (rst),
    .add   (slow_sample),
    .val   (vapour),
    .clr   (query),
    .sum_q (e_sum),
    .cnt_q (e_cnt)
  );
  wsa_acc u_acc_p (
    .clk   (clk),
    .rst   (rst),
    .add   (slow_sample),
    .val   (baro),
    .clr   (query),
    .sum_q (p_sum),
    .cnt_q (p_cnt)
  );
  wsa_acc u_acc_d (
    .clk   (clk),
    .rst   (rst),
    .add   (strike_ok),
    .val   ({{(wsa_pkg::DW-wsa_pkg::DSTW){1'b0}}, strike_dist}),
    .clr   (query),
    .sum_q (d_sum),
    .cnt_q (d_cnt)
  );

  // gust, rain, threshold
  logic signed [wsa_pkg::DW-1:0]   gust_q, gust_d;
  logic        [31:0]              rtot_q, rtot_d, min_um_q, min_um_d, mmh;
  logic        [15:0]              imax_q, imax_d, rate_q, rate_d, mdrops_q, mdrops_d;
  logic        [15:0]              cut, drop_um, int_now;
  logic        [wsa_pkg::LVLW-1:0] thr_d;

  always_comb begin
    gust_d = query ? '0 : gust_q;
    if (wind_ok && (wind_speed > gust_d)) begin
      gust_d = wind_speed;
    end
    cut      = rate_q >> wsa_pkg::DROP_CUT_SHIFT;
    cut      = (cut > wsa_pkg::DROP_CUT_MAX) ? wsa_pkg::DROP_CUT_MAX : cut;
    drop_um  = wsa_pkg::DROP_BASE_UM - cut;
    mmh      = (min_um_q * wsa_pkg::UM_TO_MMH_MUL) / wsa_pkg::UM_TO_MMH_DIV;
    int_now  = (mmh > 32'(wsa_pkg::INT_CAP_MMH)) ? wsa_pkg::INT_CAP_MMH : mmh[15:0];
    rtot_d   = (query ? 32'h0000_0000 : rtot_q) + (rain_drop ? 32'(drop_um) : 32'h0000_0000);
    imax_d   = query ? 16'h0000 : imax_q;
    min_um_d = min_um_q;
    mdrops_d = mdrops_q;
    rate_d   = rate_q;
    if (slow_sample) begin
      imax_d   = (int_now > imax_d) ? int_now : imax_d;
      rate_d   = mdrops_q;
      min_um_d = 32'h0000_0000;
      mdrops_d = 16'h0000;
    end
    if (rain_drop) begin
      min_um_d = min_um_d + 32'(drop_um);
      mdrops_d = (mdrops_d == 16'hFFFF) ? mdrops_d : mdrops_d + 16'h0001;
    end
    thr_d = thr_save ? thr_value : thr_level_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gust_q      <= '0;
      rtot_q      <= 32'h0000_0000;
      min_um_q    <= 32'h0000_0000;
      imax_q      <= 16'h0000;
      rate_q      <= 16'h0000;
      mdrops_q    <= 16'h0000;
      thr_level_q <= wsa_pkg::THR_DEFAULT;
    end else begin
      gust_q      <= gust_d;
      rtot_q      <= rtot_d;
      min_um_q    <= min_um_d;
      imax_q      <= imax_d;
      rate_q      <= rate_d;
      mdrops_q    <= mdrops_d;
      thr_level_q <= thr_d;
    end
  end

  // report latch
  logic                          rv_d, werr_d;
  logic signed [wsa_pkg::DW-1:0] um_d, vm_d, sm_d, g_d, tm_d, em_d, pm_d;
  logic        [31:0]            rt_d;
  logic        [15:0]            rmax_d, dm_w;
  logic        [wsa_pkg::CNTW-1:0] sc_d;
  logic        [wsa_pkg::DSTW-1:0] dm_d;

  always_comb begin
    rv_d   = query;
    werr_d = wind_error_q;
    um_d   = wind_u_mean_q;
    vm_d   = wind_v_mean_q;
    sm_d   = wind_speed_mean_q;
    g_d    = wind_gust_q;
    tm_d   = temp_mean_q;
    em_d   = vapour_mean_q;
    pm_d   = baro_mean_q;
    rt_d   = rain_total_q;
    rmax_d = rain_max_mmh_q;
    sc_d   = strike_count_q;
    dm_d   = strike_dist_mean_q;
    dm_w   = mean_of(d_sum, d_cnt);
    if (query) begin
      werr_d = (s_cnt == '0);
      um_d   = mean_of(u_sum, u_cnt);
      vm_d   = mean_of(v_sum, v_cnt);
      sm_d   = mean_of(s_sum, s_cnt);
      g_d    = gust_q;
      tm_d   = mean_of(t_sum, t_cnt);
      em_d   = mean_of(e_sum, e_cnt);
      pm_d   = mean_of(p_sum, p_cnt);
      rt_d   = rtot_q;
      rmax_d = imax_q;
      sc_d   = d_cnt;
      dm_d   = dm_w[wsa_pkg::DSTW-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      report_valid_q     <= 1'b0;
      wind_error_q       <= 1'b0;
      wind_u_mean_q      <= '0;
      wind_v_mean_q      <= '0;
      wind_speed_mean_q  <= '0;
      wind_gust_q        <= '0;
      temp_mean_q        <= '0;
      vapour_mean_q      <= '0;
      baro_mean_q        <= '0;
      rain_total_q       <= 32'h0000_0000;
      rain_max_mmh_q     <= 16'h0000;
      strike_count_q     <= '0;
      strike_dist_mean_q <= '0;
    end else begin
      report_valid_q     <= rv_d;
      wind_error_q       <= werr_d;
      wind_u_mean_q      <= um_d;
      wind_v_mean_q      <= vm_d;
      wind_speed_mean_q  <= sm_d;
      wind_gust_q        <= g_d;
      temp_mean_q        <= tm_d;
      vapour_mean_q      <= em_d;
      baro_mean_q        <= pm_d;
      rain_total_q       <= rt_d;
      rain_max_mmh_q     <= rmax_d;
      strike_count_q     <= sc_d;
      strike_dist_mean_q <= dm_d;
    end
  end
endmodule // wsa_top
`default_nettype wire

// File: verification/wsa_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wsa_checker #(
  parameter int TICK_CYCLES = wsa_pkg::TICK_CYC
) (
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic                           query,
  input wire logic        [wsa_pkg::LVLW-1:0] thr_value,
  input wire logic                           thr_save,
  input wire logic                           fast_sample,
  input wire logic                           slow_sample,
  input wire logic                           spike_q,
  input wire logic                           report_valid_q,
  input wire logic                           wind_error_q,
  input wire logic signed [wsa_pkg::DW-1:0]   wind_u_mean_q,
  input wire logic signed [wsa_pkg::DW-1:0]   wind_speed_mean_q,
  input wire logic signed [wsa_pkg::DW-1:0]   wind_gust_q,
  input wire logic        [31:0]              rain_total_q,
  input wire logic        [15:0]              rain_max_mmh_q,
  input wire logic        [wsa_pkg::CNTW-1:0] strike_count_q,
  input wire logic        [wsa_pkg::LVLW-1:0] thr_level_q
);
  localparam logic [31:0] FAST_GAP = 32'(wsa_pkg::FAST_PERIOD_S * TICK_CYCLES - 1);
  logic [31:0] gap_q;
  logic [31:0] gap_d;
  logic        seen_q;
  logic        seen_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since the last wind strobe
  always_comb begin
    gap_d  = fast_sample ? 32'h0 : gap_q + 32'h1;
    seen_d = seen_q | fast_sample;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end
  property p_fast_period; fast_sample && seen_q |-> gap_q == FAST_GAP; endproperty
  a_fast_period: assert property (p_fast_period) else $error("wind strobe period wrong");
  property p_fast_due; gap_q <= FAST_GAP; endproperty
  a_fast_due: assert property (p_fast_due) else $error("wind strobe overdue");
  property p_slow_on_fast; slow_sample |-> fast_sample; endproperty
  a_slow_on_fast: assert property (p_slow_on_fast) else $error("slow strobe off the tick");
  property p_report; query |=> report_valid_q; endproperty
  a_report: assert property (p_report) else $error("query not answered");
  property p_report_cause; report_valid_q |-> $past(query); endproperty
  a_report_cause: assert property (p_report_cause) else $error("report without query");
  property p_hold;
    !report_valid_q |-> $stable(strike_count_q) && $stable(rain_total_q) && $stable(wind_gust_q);
  endproperty
  a_hold: assert property (p_hold) else $error("report changed between queries");
  property p_gust; report_valid_q && !wind_error_q |-> wind_gust_q >= wind_speed_mean_q; endproperty
  a_gust: assert property (p_gust) else $error("gust below mean speed");
  property p_err; wind_error_q |-> wind_gust_q == 0 && wind_u_mean_q == 0 && wind_speed_mean_q == 0; endproperty
  a_err: assert property (p_err) else $error("wind values beside error");
  property p_cap; rain_max_mmh_q <= wsa_pkg::INT_CAP_MMH; endproperty
  a_cap: assert property (p_cap) else $error("intensity above cap");
  property p_spike; spike_q |-> $past(fast_sample); endproperty
  a_spike: assert property (p_spike) else $error("spike flag without sample");
  property p_thr; thr_save |=> thr_level_q == $past(thr_value); endproperty
  a_thr: assert property (p_thr) else $error("threshold not loaded");
  property p_thr_hold; !thr_save |=> $stable(thr_level_q); endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved unsaved");
  c_spike: cover property (spike_q);
  c_err: cover property (report_valid_q && wind_error_q);
  c_cap: cover property (report_valid_q && rain_max_mmh_q == wsa_pkg::INT_CAP_MMH);
endmodule // wsa_checker
bind wsa_top wsa_checker #(.TICK_CYCLES(TICK_CYCLES)) u_wsa_checker (
  .clk(clk), .rst(rst), .query(query), .thr_value(thr_value), .thr_save(thr_save),
  .fast_sample(fast_sample), .slow_sample(slow_sample), .spike_q(spike_q),
  .report_valid_q(report_valid_q), .wind_error_q(wind_error_q), .wind_u_mean_q(wind_u_mean_q),
  .wind_speed_mean_q(wind_speed_mean_q), .wind_gust_q(wind_gust_q), .rain_total_q(rain_total_q),
  .rain_max_mmh_q(rain_max_mmh_q), .strike_count_q(strike_count_q), .thr_level_q(thr_level_q));
`default_nettype wire

// File: verification/wsa_logger.sv
`timescale 1ns/1ps
`default_nettype none
module wsa_logger (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ask,
  input  wire logic                     set_thr,
  input  wire logic [wsa_pkg::LVLW-1:0] new_thr,
  output logic                          query,
  output logic                          thr_save,
  output logic      [wsa_pkg::LVLW-1:0] thr_value
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      query     <= 1'b0;
      thr_save  <= 1'b0;
      thr_value <= wsa_pkg::THR_DEFAULT;
    end else begin
      query    <= ask;
      thr_save <= set_thr;
      if (set_thr) begin
        thr_value <= new_thr;
      end
    end
  end
endmodule // wsa_logger
`default_nettype wire

// File: verification/wsa_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wsa_bench;
  typedef struct {
    logic signed [15:0] spd, u, v, tmp;
    int nf, nd, ns;
    logic [3:0] lvl;
    logic [7:0] dst;
    logic [15:0] e_cnt;
    logic [31:0] e_rain;
  } wsa_row_t;
  wsa_row_t rows [3] = '{
    '{16'sd20, 16'sd12, -16'sd16, -16'sd50, 2, 3, 2, 4'h6, 8'h0E, 16'h0002, 32'h0000_0033},
    '{16'sd40, -16'sd30, 16'sd25, 16'sd215, 1, 0, 3, 4'h5, 8'h09, 16'h0000, 32'h0000_0000},
    '{16'sd30, 16'sd5, 16'sd7, 16'sd0, 3, 5, 1, 4'hF, 8'h28, 16'h0001, 32'h0000_0055}};
  logic clk, rst, ask, set_thr, query, thr_save, rain_drop, strike_evt;
  logic [3:0] new_thr, thr_value, strike_level, thr_level_q;
  logic signed [15:0] wind_u, wind_v, wind_speed, air_temp, vapour, baro;
  logic signed [15:0] wind_u_mean_q, wind_v_mean_q, wind_speed_mean_q, wind_gust_q;
  logic signed [15:0] temp_mean_q, vapour_mean_q, baro_mean_q;
  logic [7:0] strike_dist, strike_dist_mean_q;
  logic fast_sample, slow_sample, spike_q, report_valid_q, wind_error_q;
  logic [31:0] rain_total_q;
  logic [15:0] rain_max_mmh_q, strike_count_q;
  int errors, total_checks;
  wsa_top #(.TICK_CYCLES(8)) u_wsa_top (.clk(clk), .rst(rst), .query(query), .wind_u(wind_u),
    .wind_v(wind_v), .wind_speed(wind_speed), .air_temp(air_temp), .vapour(vapour), .baro(baro),
    .rain_drop(rain_drop), .strike_evt(strike_evt), .strike_level(strike_level),
    .strike_dist(strike_dist), .thr_value(thr_value), .thr_save(thr_save),
    .fast_sample(fast_sample), .slow_sample(slow_sample), .spike_q(spike_q),
    .report_valid_q(report_valid_q), .wind_error_q(wind_error_q), .wind_u_mean_q(wind_u_mean_q),
    .wind_v_mean_q(wind_v_mean_q), .wind_speed_mean_q(wind_speed_mean_q), .wind_gust_q(wind_gust_q),
    .temp_mean_q(temp_mean_q), .vapour_mean_q(vapour_mean_q), .baro_mean_q(baro_mean_q),
    .rain_total_q(rain_total_q), .rain_max_mmh_q(rain_max_mmh_q), .strike_count_q(strike_count_q),
    .strike_dist_mean_q(strike_dist_mean_q), .thr_level_q(thr_level_q));
  wsa_logger u_wsa_logger (.clk(clk), .rst(rst), .ask(ask), .set_thr(set_thr), .new_thr(new_thr),
    .query(query), .thr_save(thr_save), .thr_value(thr_value));
  always #12.5 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // 0 wind strobe, 1 slow strobe, 2 report
  task automatic wait_sig(input int which);
    bit hit;
    hit = 0;
    for (int n = 0; n < 2000 && !hit; n++) begin
      @(negedge clk);
      hit = (which == 0) ? fast_sample === 1'b1 : (which == 1) ? slow_sample === 1'b1 : report_valid_q === 1'b1;
    end
    if (!hit) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict;
    end
  endtask
  task automatic ask_q;
    @(posedge clk) ask <= 1'b1;
    @(posedge clk) ask <= 1'b0;
    wait_sig(2);
  endtask
  task automatic thr_case(input logic [3:0] thr, input logic [3:0] lvl, input logic [15:0] exp);
    @(posedge clk) begin
      set_thr <= 1'b1;
      new_thr <= thr;
    end
    @(posedge clk) set_thr <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(thr_level_q, thr);
    @(posedge clk) begin
      strike_level <= lvl;
      strike_evt <= 1'b1;
    end
    @(posedge clk) strike_evt <= 1'b0;
    ask_q;
    chk(strike_count_q, exp);
  endtask
  initial begin
    clk = 0;
    rst = 1;
    ask = 0;
    set_thr = 0;
    new_thr = 4'h0;
    rain_drop = 0;
    strike_evt = 0;
    wind_u = 16'h0000;
    wind_v = 16'h0000;
    wind_speed = 16'h0000;
    air_temp = 16'h0000;
    vapour = 16'h000C;
    baro = 16'hFFF9;
    strike_level = 4'h0;
    strike_dist = 8'h00;
    errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(thr_level_q, 4'h5);
    chk(strike_count_q, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clk) begin
        wind_speed <= rows[i].spd;
        wind_u <= rows[i].u;
        wind_v <= rows[i].v;
        air_temp <= rows[i].tmp;
        strike_level <= rows[i].lvl;
        strike_dist <= rows[i].dst;
      end
      for (int k = 0; k < rows[i].nf; k++) wait_sig(0);
      for (int k = 0; k < 8; k++) begin
        @(posedge clk) begin
          rain_drop <= k < rows[i].nd;
          strike_evt <= k < rows[i].ns;
        end
      end
      @(posedge clk) begin
        rain_drop <= 1'b0;
        strike_evt <= 1'b0;
      end
      ask_q;
      chk(wind_speed_mean_q, rows[i].spd);
      chk(wind_gust_q, rows[i].spd);
      chk(wind_u_mean_q, rows[i].u);
      chk(wind_v_mean_q, rows[i].v);
      chk(temp_mean_q, rows[i].tmp);
      chk(rain_total_q, rows[i].e_rain);
      chk(strike_count_q, rows[i].e_cnt);
      chk(strike_dist_mean_q, rows[i].e_cnt != 0 ? rows[i].dst : 8'h00);
    end
    // lone spike interval: rejected, so no wind data
    @(posedge clk) wind_speed <= 16'sh1000;
    wait_sig(0);
    @(posedge clk) wind_speed <= 16'sd30;
    @(negedge clk);
    chk(spike_q, 1'b1);
    ask_q;
    chk(wind_error_q, 1'b1);
    chk(wind_gust_q, 16'h0000);
    thr_case(4'hF, 4'hF, 16'h0000);
    thr_case(4'h0, 4'h1, 16'h0001);
    // one drop, then two queries in consecutive cycles
    @(posedge clk) rain_drop <= 1'b1;
    @(posedge clk) begin
      rain_drop <= 1'b0;
      ask <= 1'b1;
    end
    @(posedge clk);
    @(posedge clk) ask <= 1'b0;
    wait_sig(2);
    chk(rain_total_q, 32'h0000_0011);
    @(negedge clk);
    chk(report_valid_q, 1'b1);
    chk(rain_total_q, 32'h0000_0000);
    // a whole minute of drops drives intensity into the cap
    wait_sig(1);
    @(posedge clk) rain_drop <= 1'b1;
    wait_sig(1);
    @(posedge clk) rain_drop <= 1'b0;
    ask_q;
    chk(rain_max_mmh_q, 16'h0118);
    chk(vapour_mean_q, vapour);
    chk(baro_mean_q, baro);
    chk(rain_total_q, 32'h0000_1FE0);
    // a busy minute shrinks the next drop
    @(posedge clk) rain_drop <= 1'b1;
    @(posedge clk) rain_drop <= 1'b0;
    ask_q;
    chk(rain_total_q, 32'h0000_0009);
    print_verdict;
  end
endmodule // wsa_bench
`default_nettype wire
